// file: src/cmm_pkg.sv
// constants shared by the core memory map and sfr paging block
package cmm_pkg;

	// program memory limits
	localparam logic [15:0] FLASH_TOP_32K = 16'h7BFF;
	localparam logic [15:0] FLASH_TOP_16K = 16'h3FFF;

	// data memory layout
	localparam logic [7:0] DIRECT_TOP  = 8'h7F;
	localparam logic [7:0] BANK_TOP    = 8'h1F;
	localparam logic [7:0] BIT_BASE    = 8'h20;
	localparam int         REG_PER_BNK = 8;

	// sfr addresses held or watched by this block
	localparam logic [7:0] SP_ADDR    = 8'h81;
	localparam logic [7:0] NEXT_ADDR  = 8'h85;
	localparam logic [7:0] LAST_ADDR  = 8'h86;
	localparam logic [7:0] PSCTL_ADDR = 8'h8F;
	localparam logic [7:0] PAGE_ADDR  = 8'hA7;
	localparam logic [7:0] PSW_ADDR   = 8'hD0;
	localparam logic [7:0] PCTL_ADDR  = 8'hE5;
	localparam logic [7:0] PORT0_ADDR = 8'h80;
	localparam logic [7:0] PORT1_ADDR = 8'h90;
	localparam logic [7:0] PORT2_ADDR = 8'hA0;
	localparam logic [7:0] PORT3_ADDR = 8'hB0;

	// field positions
	localparam int PSWE_BIT    = 0;
	localparam int AUTO_EN_BIT = 0;
	localparam int BANK_LO_BIT = 3;
	localparam int BANK_HI_BIT = 4;

	// reset values
	localparam logic [7:0] SP_RESET      = 8'h07;
	localparam logic [7:0] PAGE_RESET    = 8'h00;
	localparam logic       AUTO_EN_RESET = 1'b1;
	localparam logic       PSWE_RESET    = 1'b0;
	localparam logic [1:0] BANK_RESET    = 2'h0;

	// pages
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	localparam logic [7:0] PAGE_F    = 8'h0F;

	// debug stack record
	localparam int REC_WIDTH = 32;

	// where a data access lands
	typedef enum logic [1:0] {
		CMM_TGT_NONE = 2'b00,
		CMM_TGT_RAM  = 2'b01,
		CMM_TGT_SFR  = 2'b10
	} cmm_target_t;

endpackage

// file: src/cmm_page_stack.sv
// three-byte sfr page stack with automatic switching on interrupts
`timescale 1ns/1ps
module cmm_page_stack (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// interrupt events
	input  wire logic       irq_entry_i,
	input  wire logic       irq_return_i,
	input  wire logic       auto_en_i,
	// software writes
	input  wire logic       wr_page_i,
	input  wire logic       wr_next_i,
	input  wire logic       wr_last_i,
	input  wire logic [7:0] wdata_i,
	// stack contents
	output logic      [7:0] page_o,
	output logic      [7:0] next_o,
	output logic      [7:0] last_o
);

	logic [7:0] page_reg;
	logic [7:0] page_next;
	logic [7:0] next_reg;
	logic [7:0] next_next;
	logic [7:0] last_reg;
	logic [7:0] last_next;
	logic       push_w;
	logic       pop_w;

	// stack moves only on interrupt events, and only when auto paging is on
	assign push_w = irq_entry_i & auto_en_i;                  // R18 R23
	assign pop_w  = irq_return_i & auto_en_i & ~irq_entry_i; // R19 R23

	// a hardware push or pop beats a software write in the same cycle
	assign page_next = push_w ? cmm_pkg::PAGE_ZERO :          // R18
	                   pop_w ? next_reg :                     // R19
	                   wr_page_i ? wdata_i : page_reg;
	assign next_next = push_w ? page_reg :                    // R18
	                   pop_w ? last_reg :                     // R19
	                   wr_next_i ? wdata_i : next_reg;        // R20
	assign last_next = push_w ? next_reg :                    // R18
	                   pop_w ? cmm_pkg::PAGE_RESET :          // R19
	                   wr_last_i ? wdata_i : last_reg;        // R20

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			page_reg <= cmm_pkg::PAGE_RESET; // R24
			next_reg <= cmm_pkg::PAGE_RESET; // R24
			last_reg <= cmm_pkg::PAGE_RESET; // R24
		end else begin
			page_reg <= page_next;
			next_reg <= next_next;
			last_reg <= last_next;
		end
	end

	assign page_o = page_reg;
	assign next_o = next_reg;
	assign last_o = last_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_entry;
		irq_entry_i && auto_en_i;
	endsequence

	a_push_shift: assert property (s_entry |=> page_reg == 8'h00 && // R18
		next_reg == $past(page_reg) && last_reg == $past(next_reg))
		else $error("page stack push wrong");
	a_pop_shift: assert property (irq_return_i && !irq_entry_i && auto_en_i |=> // R19
		page_reg == $past(next_reg) && next_reg == $past(last_reg) && last_reg == 8'h00)
		else $error("page stack pop wrong");
	a_auto_off_hold: assert property (!auto_en_i && !wr_page_i && !wr_next_i && // R23
		!wr_last_i |=> $stable(page_reg) && $stable(next_reg) && $stable(last_reg))
		else $error("page stack moved with auto paging off");
	a_sw_no_push: assert property (wr_next_i && !irq_entry_i && !irq_return_i |=> // R20
		next_reg == $past(wdata_i) && $stable(page_reg) && $stable(last_reg))
		else $error("software write moved page stack");

endmodule

// file: src/cmm_stack_record.sv
// debug stack record shift register with overflow and underflow detection
`timescale 1ns/1ps
module cmm_stack_record #(
	parameter int WIDTH = cmm_pkg::REC_WIDTH
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	// record events
	input  wire logic             add_one_i,
	input  wire logic             add_two_i,
	input  wire logic             rem_one_i,
	input  wire logic             rem_two_i,
	// record state
	output logic      [WIDTH-1:0] record_o,
	output logic      [5:0]       depth_o,
	output logic                  overflow_o,
	output logic                  underflow_o
);

	logic [WIDTH-1:0] rec_reg;
	logic [WIDTH-1:0] rec_next;
	logic [5:0]       depth_reg;
	logic [5:0]       depth_next;
	logic             ovf_reg;
	logic             unf_reg;
	logic             ovf_w;
	logic             unf_w;
	logic [5:0]       add_n;
	logic [5:0]       rem_n;

	assign add_n = add_two_i ? 6'h02 : {5'h00, add_one_i};
	assign rem_n = rem_two_i ? 6'h02 : {5'h00, rem_one_i};

	// depth saturates so a runaway push or pop is flagged, not wrapped
	assign ovf_w = (depth_reg + add_n) > 6'(WIDTH);  // R13
	assign unf_w = depth_reg < rem_n;                // R13

	// push bits are 0, call bits are 1, so the debugger can tell them apart
	assign rec_next = add_two_i ? {rec_reg[WIDTH-3:0], 2'b11} :   // R12
	                  add_one_i ? {rec_reg[WIDTH-2:0], 1'b0} :    // R12
	                  rem_two_i ? {2'b00, rec_reg[WIDTH-1:2]} :   // R12
	                  rem_one_i ? {1'b0, rec_reg[WIDTH-1:1]} : rec_reg;
	assign depth_next = (add_one_i | add_two_i) ? (ovf_w ? 6'(WIDTH) : depth_reg + add_n) :
	                    (unf_w ? 6'h00 : depth_reg - rem_n);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			rec_reg   <= '0;
			depth_reg <= 6'h00;
			ovf_reg   <= 1'b0;
			unf_reg   <= 1'b0;
		end else begin
			rec_reg   <= rec_next;
			depth_reg <= depth_next;
			ovf_reg   <= (add_one_i | add_two_i) & ovf_w;  // R13
			unf_reg   <= (rem_one_i | rem_two_i) & ~(add_one_i | add_two_i) & unf_w; // R13
		end
	end

	assign record_o    = rec_reg;
	assign depth_o     = depth_reg;
	assign overflow_o  = ovf_reg;
	assign underflow_o = unf_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_rec_overflow: assert property (depth_reg == 6'd32 && add_one_i |=> ovf_reg) // R13
		else $error("stack record overflow missed");
	a_rec_underflow: assert property (depth_reg == 6'd1 && rem_two_i && !add_one_i && // R13
		!add_two_i |=> unf_reg)
		else $error("stack record underflow missed");
	a_rec_call_two: assert property (add_two_i && depth_reg < 6'd31 |=> // R12
		depth_reg == $past(depth_reg) + 6'd2 && rec_reg[1:0] == 2'b11)
		else $error("call did not add two record bits");

endmodule

// file: src/cmm_mem_map.sv
// memory space decoder, stack pointer and sfr paging for the 8051 style core
`timescale 1ns/1ps
// What this block does
// R1: 32k part: flash 0 to 0x7BFF, rest reserved
// R2: 16k part: flash 0 to 0x3FFF
// R3: program writes need store write enable set
// R4: 256 byte ram, low half direct or indirect
// R5: above 0x7F: direct to sfr, indirect ram
// R6: 0x00-0x1F four banks, chosen by status bits
// R7: index registers are bank registers zero, one
// R8: 0x20-0x2F bits: eight times offset plus position
// R9: bit versus byte chosen by operand type
// R10: push writes pointer plus one, then increments
// R11: reset loads stack pointer with 0x07
// R12: 32 bit record: push one, call two
// R13: record overflow and underflow flagged at speed
// R14: sfr addresses ending 0 or 8 bit-addressable
// R15: software avoids unoccupied sfr addresses
// R16: page register picks page; pages 0, F exist
// R17: software selects page, then moves directly
// R18: interrupt entry pushes page stack, page zero
// R19: interrupt return pops; last becomes zero
// R20: page stack writes do not push or pop
// R21: auto page enable resets to enabled
// R22: port registers decoded on every page
// R23: auto paging off: no switch, no push, pop
// R24: page stack registers reset to zero
module cmm_mem_map #(
	parameter logic FLASH_32K = 1'b1
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// program memory access
	input  wire logic [15:0] code_addr_i,
	input  wire logic        code_rd_i,
	input  wire logic        code_wr_i,
	output logic             code_hit_o,
	output logic             code_reserved_o,
	output logic             code_store_wr_o,
	// data memory access
	input  wire logic        acc_en_i,
	input  wire logic        acc_wr_i,
	input  wire logic        acc_indirect_i,
	input  wire logic        acc_bit_i,
	input  wire logic [7:0]  acc_addr_i,
	input  wire logic [7:0]  acc_wdata_i,
	output logic      [1:0]  tgt_o,
	output logic      [7:0]  tgt_addr_o,
	output logic      [2:0]  tgt_bit_o,
	output logic             tgt_bitable_o,
	output logic             page_unimpl_o,
	output logic      [7:0]  rd_data_o,
	output logic             rd_valid_o,
	// register bank access
	input  wire logic [2:0]  rn_i,
	input  wire logic        idx_sel_i,
	output logic      [7:0]  rn_addr_o,
	output logic      [7:0]  idx_addr_o,
	// stack and interrupts
	input  wire logic        push_i,
	input  wire logic        pop_i,
	input  wire logic        call_i,
	input  wire logic        ret_i,
	input  wire logic        irq_entry_i,
	input  wire logic        irq_return_i,
	output logic      [7:0]  sp_o,
	output logic      [7:0]  stack_addr_o,
	output logic      [7:0]  page_o,
	output logic             rec_overflow_o,
	output logic             rec_underflow_o
);

	// sfrs seen regardless of the page register
	function automatic logic is_global(input logic [7:0] a);
		is_global = (a == cmm_pkg::PORT0_ADDR) || (a == cmm_pkg::PORT1_ADDR) ||
		            (a == cmm_pkg::PORT2_ADDR) || (a == cmm_pkg::PORT3_ADDR) ||
		            (a == cmm_pkg::SP_ADDR) || (a == cmm_pkg::PSW_ADDR) ||
		            (a == cmm_pkg::PAGE_ADDR) || (a == cmm_pkg::NEXT_ADDR) ||
		            (a == cmm_pkg::LAST_ADDR);
	endfunction

	logic [7:0]  sp_reg;
	logic [7:0]  sp_next;
	logic        pswe_reg;
	logic        auto_en_reg;
	logic [1:0]  bank_reg;
	logic [1:0]  bank_next;
	logic [1:0]  tgt_reg;
	logic [7:0]  tgt_addr_reg;
	logic [2:0]  tgt_bit_reg;
	logic        tgt_bitable_reg;
	logic        page_unimpl_reg;
	logic [7:0]  rd_data_reg;
	logic        rd_valid_reg;
	logic        code_hit_reg;
	logic        code_rsv_reg;
	logic        code_wr_reg;
	logic [7:0]  rn_addr_reg;
	logic [7:0]  idx_addr_reg;
	logic [7:0]  stack_addr_reg;
	logic [7:0]  page_w;
	logic [7:0]  next_w;
	logic [7:0]  last_w;
	logic [15:0] flash_top_w;
	logic        code_in_w;
	logic        sfr_w;
	logic [7:0]  byte_addr_w;
	logic        global_w;
	logic        visible_w;
	logic [7:0]  own_data_w;
	logic        own_w;
	logic [7:0]  wbyte_w;
	logic        wr_sp_w;
	logic        wr_page_w;
	logic        wr_next_w;
	logic        wr_last_w;
	logic        wr_pctl_w;
	logic        wr_psctl_w;
	logic        wr_psw_w;
	logic        sp_inc_w;
	logic        sp_dec_w;
	logic        rec_ovf_w;
	logic        rec_unf_w;

	// program memory range
	assign flash_top_w = FLASH_32K ? cmm_pkg::FLASH_TOP_32K : cmm_pkg::FLASH_TOP_16K; // R1 R2
	assign code_in_w   = code_addr_i <= flash_top_w; // R1 R2

	// bit accesses map by address bit 7, never by indirect mode
	assign sfr_w = acc_bit_i ? acc_addr_i[7] :                          // R9
	               (~acc_indirect_i & (acc_addr_i > cmm_pkg::DIRECT_TOP)); // R5
	assign byte_addr_w = !acc_bit_i ? acc_addr_i :
	                     acc_addr_i[7] ? {acc_addr_i[7:3], 3'h0} :       // R14
	                     cmm_pkg::BIT_BASE + {4'h0, acc_addr_i[6:3]};   // R8

	// paged sfr visibility
	assign global_w  = is_global(byte_addr_w);                             // R22
	assign visible_w = global_w ||
	                   ((byte_addr_w == cmm_pkg::PSCTL_ADDR) && (page_w == cmm_pkg::PAGE_ZERO)) ||
	                   ((byte_addr_w == cmm_pkg::PCTL_ADDR) && (page_w == cmm_pkg::PAGE_F)); // R16

	// registers held here; reads of anything else come from the core's own sfrs
	always_comb begin
		own_data_w = 8'h00;
		own_w      = 1'b1;
		unique case (byte_addr_w)
			cmm_pkg::SP_ADDR:    own_data_w = sp_reg;
			cmm_pkg::PAGE_ADDR:  own_data_w = page_w;
			cmm_pkg::NEXT_ADDR:  own_data_w = next_w;
			cmm_pkg::LAST_ADDR:  own_data_w = last_w;
			cmm_pkg::PSCTL_ADDR: own_data_w = {7'h00, pswe_reg};
			cmm_pkg::PCTL_ADDR:  own_data_w = {7'h00, auto_en_reg};
			cmm_pkg::PSW_ADDR:   own_data_w = {3'h0, bank_reg, 3'h0};
			default:             own_w      = 1'b0;
		endcase
	end

	// a bit write changes only the addressed bit of the byte
	assign wbyte_w = acc_bit_i ?
	                 ((own_data_w & ~(8'h01 << acc_addr_i[2:0])) |
	                  ({7'h00, acc_wdata_i[0]} << acc_addr_i[2:0])) : acc_wdata_i;

	assign wr_sp_w    = acc_en_i & acc_wr_i & sfr_w & (byte_addr_w == cmm_pkg::SP_ADDR);
	assign wr_page_w  = acc_en_i & acc_wr_i & sfr_w & (byte_addr_w == cmm_pkg::PAGE_ADDR); // R17
	assign wr_next_w  = acc_en_i & acc_wr_i & sfr_w & (byte_addr_w == cmm_pkg::NEXT_ADDR);
	assign wr_last_w  = acc_en_i & acc_wr_i & sfr_w & (byte_addr_w == cmm_pkg::LAST_ADDR);
	assign wr_psw_w   = acc_en_i & acc_wr_i & sfr_w & (byte_addr_w == cmm_pkg::PSW_ADDR);
	assign wr_psctl_w = acc_en_i & acc_wr_i & sfr_w & visible_w &
	                    (byte_addr_w == cmm_pkg::PSCTL_ADDR);
	assign wr_pctl_w  = acc_en_i & acc_wr_i & sfr_w & visible_w &
	                    (byte_addr_w == cmm_pkg::PCTL_ADDR);

	// an instruction that moves the pointer by one also counts in the record
	assign sp_inc_w = push_i | (wr_sp_w & (wbyte_w == sp_reg + 8'h01));
	assign sp_dec_w = pop_i | (wr_sp_w & (wbyte_w == sp_reg - 8'h01));

	assign sp_next = call_i ? sp_reg + 8'h02 :
	                 ret_i ? sp_reg - 8'h02 :
	                 push_i ? sp_reg + 8'h01 :  // R10
	                 pop_i ? sp_reg - 8'h01 :
	                 wr_sp_w ? wbyte_w : sp_reg;

	assign bank_next = wr_psw_w ? {wbyte_w[cmm_pkg::BANK_HI_BIT], wbyte_w[cmm_pkg::BANK_LO_BIT]}
	                            : bank_reg; // R6

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sp_reg      <= cmm_pkg::SP_RESET;      // R11
			pswe_reg    <= cmm_pkg::PSWE_RESET;
			auto_en_reg <= cmm_pkg::AUTO_EN_RESET; // R21
			bank_reg    <= cmm_pkg::BANK_RESET;
		end else begin
			sp_reg   <= sp_next;
			bank_reg <= bank_next;
			if (wr_psctl_w) begin
				pswe_reg <= wbyte_w[cmm_pkg::PSWE_BIT]; // R3
			end
			if (wr_pctl_w) begin
				auto_en_reg <= wbyte_w[cmm_pkg::AUTO_EN_BIT]; // R21
			end
		end
	end

	// registered decode results, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			tgt_reg         <= cmm_pkg::CMM_TGT_NONE;
			tgt_addr_reg    <= 8'h00;
			tgt_bit_reg     <= 3'h0;
			tgt_bitable_reg <= 1'b0;
			page_unimpl_reg <= 1'b0;
			rd_data_reg     <= 8'h00;
			rd_valid_reg    <= 1'b0;
			code_hit_reg    <= 1'b0;
			code_rsv_reg    <= 1'b0;
			code_wr_reg     <= 1'b0;
			rn_addr_reg     <= 8'h00;
			idx_addr_reg    <= 8'h00;
			stack_addr_reg  <= 8'h00;
		end else begin
			tgt_reg <= !acc_en_i ? cmm_pkg::CMM_TGT_NONE :
			           sfr_w ? cmm_pkg::CMM_TGT_SFR : cmm_pkg::CMM_TGT_RAM; // R4 R5
			tgt_addr_reg    <= byte_addr_w;
			tgt_bit_reg     <= acc_bit_i ? acc_addr_i[2:0] : 3'h0;
			tgt_bitable_reg <= sfr_w & (byte_addr_w[2:0] == 3'h0); // R14
			page_unimpl_reg <= acc_en_i & sfr_w & ~global_w &
			                   (page_w != cmm_pkg::PAGE_ZERO) & (page_w != cmm_pkg::PAGE_F); // R16
			rd_valid_reg    <= acc_en_i & ~acc_wr_i & sfr_w & own_w & visible_w;
			rd_data_reg     <= own_data_w;
			code_hit_reg    <= (code_rd_i | code_wr_i) & code_in_w;
			code_rsv_reg    <= (code_rd_i | code_wr_i) & ~code_in_w; // R1
			code_wr_reg     <= code_wr_i & pswe_reg & code_in_w;     // R3
			rn_addr_reg     <= {3'h0, bank_reg, rn_i};               // R6
			idx_addr_reg    <= {3'h0, bank_reg, 2'h0, idx_sel_i};    // R7
			stack_addr_reg  <= (pop_i | ret_i) ? sp_reg : sp_reg + 8'h01; // R10
		end
	end

	cmm_page_stack u_page_stack (
		.clk_i        (clk_i),
		.rst_b_i      (rst_b_i),
		.irq_entry_i  (irq_entry_i),
		.irq_return_i (irq_return_i),
		.auto_en_i    (auto_en_reg),
		.wr_page_i    (wr_page_w),
		.wr_next_i    (wr_next_w),
		.wr_last_i    (wr_last_w),
		.wdata_i      (wbyte_w),
		.page_o       (page_w),
		.next_o       (next_w),
		.last_o       (last_w)
	);

	cmm_stack_record #(
		.WIDTH (cmm_pkg::REC_WIDTH)
	) u_stack_record (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.add_one_i   (sp_inc_w),
		.add_two_i   (call_i),
		.rem_one_i   (sp_dec_w),
		.rem_two_i   (ret_i),
		.record_o    (),
		.depth_o     (),
		.overflow_o  (rec_ovf_w),
		.underflow_o (rec_unf_w)
	);

	assign code_hit_o      = code_hit_reg;
	assign code_reserved_o = code_rsv_reg;
	assign code_store_wr_o = code_wr_reg;
	assign tgt_o           = tgt_reg;
	assign tgt_addr_o      = tgt_addr_reg;
	assign tgt_bit_o       = tgt_bit_reg;
	assign tgt_bitable_o   = tgt_bitable_reg;
	assign page_unimpl_o   = page_unimpl_reg;
	assign rd_data_o       = rd_data_reg;
	assign rd_valid_o      = rd_valid_reg;
	assign rn_addr_o       = rn_addr_reg;
	assign idx_addr_o      = idx_addr_reg;
	assign sp_o            = sp_reg;
	assign stack_addr_o    = stack_addr_reg;
	assign page_o          = page_w;
	assign rec_overflow_o  = rec_ovf_w;
	assign rec_underflow_o = rec_unf_w;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_sp_reset: assert property ($rose(rst_b_i) |-> sp_reg == 8'h07) // R11
		else $error("stack pointer not 0x07 after reset");
	a_push_addr: assert property (push_i && !call_i && !ret_i |=> // R10
		stack_addr_reg == $past(sp_reg) + 8'h01 && sp_reg == $past(sp_reg) + 8'h01)
		else $error("push address or increment wrong");
	a_code_range: assert property (code_rd_i |=> // R1
		code_rsv_reg == ($past(code_addr_i) > (FLASH_32K ? 16'h7BFF : 16'h3FFF)))
		else $error("program range decode wrong");
	a_store_gate: assert property (code_wr_i && !pswe_reg |=> !code_wr_reg) // R3
		else $error("program write without enable");
	a_direct_sfr: assert property (acc_en_i && !acc_bit_i && !acc_indirect_i && // R5
		acc_addr_i[7] |=> tgt_reg == cmm_pkg::CMM_TGT_SFR)
		else $error("direct high address not sfr");
	a_indirect_ram: assert property (acc_en_i && !acc_bit_i && acc_indirect_i |=> // R4
		tgt_reg == cmm_pkg::CMM_TGT_RAM && tgt_addr_reg == $past(acc_addr_i))
		else $error("indirect access not ram");
	a_bit_map: assert property (acc_en_i && acc_bit_i && !acc_addr_i[7] |=> // R8
		tgt_addr_reg == 8'h20 + {4'h0, $past(acc_addr_i[6:3])} &&
		tgt_bit_reg == $past(acc_addr_i[2:0]))
		else $error("ram bit address mapped wrong");
	a_bank_addr: assert property (1'b1 |=> rn_addr_reg == {3'h0, $past(bank_reg), // R6
		$past(rn_i)} && idx_addr_reg[7:1] == {3'h0, $past(bank_reg), 2'h0})
		else $error("bank register address wrong");
	a_auto_reset: assert property ($rose(rst_b_i) |-> auto_en_reg) // R21
		else $error("auto paging not enabled after reset");

endmodule

// file: verification/cmm_core_model.sv
// core side model issuing code, data, stack and interrupt requests
`timescale 1ns/1ps
module cmm_core_model (
	// clock
	input  wire logic        clk_i,
	// requests toward the memory map
	output logic      [15:0] code_addr_o,
	output logic             code_rd_o,
	output logic             code_wr_o,
	output logic             acc_en_o,
	output logic             acc_wr_o,
	output logic             acc_ind_o,
	output logic             acc_bit_o,
	output logic      [7:0]  acc_addr_o,
	output logic      [7:0]  acc_wdata_o,
	output logic      [5:0]  evt_o
);
	initial begin
		{code_addr_o, code_rd_o, code_wr_o, evt_o} = '0;
		{acc_en_o, acc_wr_o, acc_ind_o, acc_bit_o, acc_addr_o, acc_wdata_o} = '0;
	end
	// occupied addresses except one probe on a missing page, page chosen before any paged move
	task automatic acc(input logic w, i, b, input logic [7:0] a, d);
		@(posedge clk_i);
		{acc_en_o, acc_wr_o, acc_ind_o, acc_bit_o} <= {1'b1, w, i, b};
		{acc_addr_o, acc_wdata_o} <= {a, d};
		@(posedge clk_i);
		acc_en_o <= 1'b0;
		// released lines show the inverse, not a stale copy
		{acc_addr_o, acc_wdata_o} <= {~a, ~d};
		#1;
	endtask
	task automatic code(input logic [15:0] a, input logic w);
		@(posedge clk_i);
		{code_addr_o, code_rd_o, code_wr_o} <= {a, ~w, w};
		@(posedge clk_i);
		{code_addr_o, code_rd_o, code_wr_o} <= {~a, 2'b00};
		#1;
	endtask
	// one hot: push, pop, call, ret, irq entry, irq return
	task automatic ev(input logic [5:0] m);
		@(posedge clk_i);
		evt_o <= m;
		@(posedge clk_i);
		evt_o <= 6'h00;
		#1;
	endtask
endmodule

// file: verification/cmm_mem_map_test.sv
// self-checking bench for the memory map and sfr paging block
`timescale 1ns/1ps
module cmm_mem_map_test;
	logic        clk_i;
	logic        rst_b_i;
	logic [2:0]  rn;
	logic        idx;
	logic [15:0] seed;
	logic [7:0]  a;
	logic [7:0]  exp_q[$];
	int          errors;
	int          num_checks;
	wire  [15:0] code_addr;
	wire  [7:0]  acc_addr, acc_wdata, tgt_addr, rd_data, rn_addr, idx_addr, sp, st_addr, page;
	wire  [5:0]  evt;
	wire  [2:0]  tgt_bit;
	wire  [1:0]  tgt;
	wire         code_rd, code_wr, acc_en, acc_wr, acc_ind, acc_bit, code_hit, code_res;
	wire         code_st, bitable, rd_valid, ovf, unimpl, unf;
	logic [7:0]  s_exp;

	cmm_core_model u_core (.clk_i(clk_i), .code_addr_o(code_addr), .code_rd_o(code_rd),
		.code_wr_o(code_wr), .acc_en_o(acc_en), .acc_wr_o(acc_wr), .acc_ind_o(acc_ind),
		.acc_bit_o(acc_bit), .acc_addr_o(acc_addr), .acc_wdata_o(acc_wdata), .evt_o(evt));

	cmm_mem_map #(.FLASH_32K(1'b1)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.code_addr_i(code_addr), .code_rd_i(code_rd), .code_wr_i(code_wr),
		.code_hit_o(code_hit), .code_reserved_o(code_res), .code_store_wr_o(code_st),
		.acc_en_i(acc_en), .acc_wr_i(acc_wr), .acc_indirect_i(acc_ind), .acc_bit_i(acc_bit),
		.acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata), .tgt_o(tgt), .tgt_addr_o(tgt_addr),
		.tgt_bit_o(tgt_bit), .tgt_bitable_o(bitable), .page_unimpl_o(unimpl),
		.rd_data_o(rd_data), .rd_valid_o(rd_valid), .rn_i(rn), .idx_sel_i(idx),
		.rn_addr_o(rn_addr), .idx_addr_o(idx_addr), .push_i(evt[0]), .pop_i(evt[1]),
		.call_i(evt[2]), .ret_i(evt[3]), .irq_entry_i(evt[4]), .irq_return_i(evt[5]),
		.sp_o(sp), .stack_addr_o(st_addr), .page_o(page), .rec_overflow_o(ovf),
		.rec_underflow_o(unf));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string n, input logic [15:0] e, s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic rd(input logic [7:0] ad, e);
		exp_q.push_back(e);
		u_core.acc(1'b0, 1'b0, 1'b0, ad, 8'h00);
	endtask

	task automatic wr(input logic [7:0] ad, d);
		u_core.acc(1'b1, 1'b0, 1'b0, ad, d);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// read answers are matched in order against the notes
	always @(posedge clk_i) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk("rd_valid", 16'h0000, 16'h0001);
			else
				chk("rd_data", exp_q.pop_front(), rd_data);
		end
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		conclude();
	end

	initial begin
		rst_b_i = 1'b0;
		rn = 3'h0;
		idx = 1'b0;
		seed = 16'd7827;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(8'h81, 8'h07);
		chk("tgt", 16'h0002, tgt);
		rd(8'h85, 8'h00);
		rd(8'h86, 8'h00);
		rd(8'hA7, 8'h00);
		$display("test reset done");
		u_core.ev(6'h01);
		chk("push_addr", 16'h0008, st_addr);
		u_core.ev(6'h04);
		chk("call_sp", 16'h000A, sp);
		u_core.ev(6'h08);
		chk("ret_addr", 16'h000A, st_addr);
		u_core.ev(6'h02);
		rd(8'h81, 8'h07);
		u_core.ev(6'h02);
		chk("underflow", 16'h0001, unf);
		wr(8'h81, 8'h30);
		rd(8'h81, 8'h30);
		repeat (32) u_core.ev(6'h01);
		chk("ovf_early", 16'h0000, ovf);
		u_core.ev(6'h01);
		chk("ovf", 16'h0001, ovf);
		// random pushes and pops against a pointer kept here
		s_exp = 8'h51;
		repeat (8) begin
			seed = lfsr(seed);
			u_core.ev({4'h0, seed[0], ~seed[0]});
			s_exp = seed[0] ? s_exp - 8'h01 : s_exp + 8'h01;
			chk("rand_sp", {8'h00, s_exp}, sp);
		end
		$display("test stack done");
		wr(8'hA7, 8'h0F);
		u_core.ev(6'h10);
		chk("page", 16'h0000, page);
		rd(8'h85, 8'h0F);
		u_core.ev(6'h10);
		rd(8'h86, 8'h0F);
		u_core.ev(6'h20);
		rd(8'h85, 8'h0F);
		rd(8'h86, 8'h00);
		u_core.ev(6'h20);
		chk("page", 16'h000F, page);
		seed = lfsr(seed);
		wr(8'h85, seed[7:0]);
		chk("page", 16'h000F, page);
		rd(8'h85, seed[7:0]);
		wr(8'hE5, 8'h00);
		u_core.ev(6'h10);
		chk("page", 16'h000F, page);
		$display("test paging done");
		u_core.acc(1'b0, 1'b0, 1'b0, 8'h90, 8'h00);
		chk("port", 16'hA401, {tgt, tgt_addr, 5'h00, bitable});
		u_core.acc(1'b0, 1'b1, 1'b0, 8'h90, 8'h00);
		chk("upper", 16'h0001, tgt);
		u_core.acc(1'b0, 1'b0, 1'b1, 8'h13, 8'h00);
		chk("bit", {3'h0, 2'h1, 8'h22, 3'h3}, {3'h0, tgt, tgt_addr, tgt_bit});
		u_core.acc(1'b0, 1'b0, 1'b0, 8'h13, 8'h00);
		chk("byte", {3'h0, 2'h1, 8'h13, 3'h0}, {3'h0, tgt, tgt_addr, tgt_bit});
		// random low addresses, mode, operand type, direction and data
		repeat (8) begin
			seed = lfsr(seed);
			a = {1'b0, seed[6:0]};
			u_core.acc(seed[10], seed[9], seed[11], a, seed[15:8]);
			chk("low_ram", {3'h0, 2'h1, seed[11] ? 8'h20 + {4'h0, a[6:3]} : a,
				seed[11] ? a[2:0] : 3'h0}, {3'h0, tgt, tgt_addr, tgt_bit});
		end
		$display("test decode done");
		wr(8'hD0, 8'h18);
		seed = lfsr(seed);
		@(posedge clk_i);
		rn <= seed[2:0];
		idx <= seed[3];
		@(posedge clk_i);
		#1;
		chk("bank", {3'h0, 2'h3, seed[2:0], 3'h0, 2'h3, 2'h0, seed[3]},
			{rn_addr, idx_addr});
		// a page that does not exist hides the paged registers
		wr(8'hA7, 8'h33);
		u_core.acc(1'b0, 1'b0, 1'b0, 8'h8F, 8'h00);
		chk("unimpl", 16'h0001, unimpl);
		wr(8'hA7, 8'h00);
		u_core.code(16'h7BFF, 1'b0);
		chk("flash_top", 16'h0001, code_hit);
		u_core.code(16'h7C00, 1'b0);
		chk("reserved", 16'h0001, code_res);
		u_core.code(16'h1000, 1'b1);
		chk("store_off", 16'h0000, code_st);
		wr(8'h8F, 8'h01);
		u_core.code(16'h1000, 1'b1);
		chk("store_on", 16'h0001, code_st);
		repeat (8) begin
			seed = lfsr(seed);
			u_core.code(seed, seed[3]);
			chk("code_rand", {13'h0000, seed <= cmm_pkg::FLASH_TOP_32K,
				seed > cmm_pkg::FLASH_TOP_32K, seed[3] && seed <= cmm_pkg::FLASH_TOP_32K},
				{13'h0000, code_hit, code_res, code_st});
		end
		$display("test bank and code done");
		repeat (3) @(posedge clk_i);
		chk("pending", 16'h0000, 16'(exp_q.size()));
		conclude();
	end
endmodule
